// ===== core/line_port_pkg.sv
// Shared constants for the eight-port line card port logic
package line_port_pkg;
  // Port count and data widths
  localparam int NPORT = 8;
  localparam int PORT_W = 3;
  localparam int BYTE_W = 8;
  localparam int SLOT_W = 8;
  localparam int DIGIT_W = 4;
  // Word carried by the transmit FIFO: {port, byte}
  localparam int TXW_W = PORT_W + BYTE_W;
  localparam int TX_FIFO_DEPTH = 4;
  // System clock rate in Hz
  localparam longint MCLK_HZ = 64'd10000000;
  // Codec bit clock rates in Hz
  localparam longint CODEC_HZ_T1 = 64'd1544000;
  localparam longint CODEC_HZ_E1 = 64'd2048000;
  // Phase accumulator width; it toggles at twice the bit rate
  localparam int NCO_W = 16;
  localparam logic [NCO_W-1:0] NCO_INC_T1 =
    NCO_W'((2 * CODEC_HZ_T1 * (64'd1 << NCO_W)) / MCLK_HZ);
  localparam logic [NCO_W-1:0] NCO_INC_E1 =
    NCO_W'((2 * CODEC_HZ_E1 * (64'd1 << NCO_W)) / MCLK_HZ);
  // Last bit index of a codec byte
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Loader index one past the last port; the transmit loader idles here
  localparam logic [PORT_W:0] LOAD_DONE = 4'h8;
  // Codec framing sequencer states
  typedef enum logic [0:0] {SEQ_SYNC, SEQ_SHIFT} seq_e;
endpackage : line_port_pkg

// ===== core/tx_fifo.sv
// Small valid/ready FIFO in flip-flops
`timescale 1ns/1ps
module tx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Storage and pointers, one extra bit to tell full from empty
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] fill;
  logic push, pop;

  // Fill level and handshake terms
  always_comb begin
    fill = wp_r - rp_r;
    in_ready = (fill != (AW+1)'(DEPTH));
    out_valid = (fill != '0);
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    out_data = mem_r[rp_r[AW-1:0]];
  end

  // Pointer registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Storage write, no reset needed for data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule : tx_fifo

// ===== core/line_port_core.sv
// Per-port PCM, codec framing, hook, digit and ring relay logic
`timescale 1ns/1ps
// Summary of operation
// - Eight independent ports with digit, hook, ring
// - Capture both buses into per-port shift registers
// - Bus select picks which register feeds codec
// - Serialise to codec, deserialise codec transmit data
// - Codec clock 1.544 or 2.048 MHz, static select
// - One rate and law setting for all codecs
// - Relay output asserted connects ring voltage
// - Off-hook while ringing drops relay, sets disable
// - Disabled until a fresh ring command
// - Digit receivers run on separate reference clock
// - Any slot on either bus per port
// - Transmit eight ports in consecutive slots
module line_port_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Backplane receive: slot strobe, frame start, bytes of both buses
  input wire logic bp_frame,
  input wire logic bp_slot_tick,
  input wire logic [7:0] bp_a_din,
  input wire logic [7:0] bp_b_din,
  // Backplane transmit: one byte with per-bus enable
  output logic [7:0] bp_dout,
  output logic bp_a_oe,
  output logic bp_b_oe,
  // Static configuration
  input wire logic rate_e1,
  input wire logic law_alaw,
  input wire logic [7:0][7:0] rx_slot,
  input wire logic [7:0] rx_bus_sel,
  input wire logic [7:0] tx_base_slot,
  input wire logic tx_bus_sel,
  // Codec serial interface, shared clock and sync
  output logic codec_clk,
  output logic codec_fs,
  output logic codec_alaw,
  output logic [7:0] codec_dout,
  input wire logic [7:0] codec_din,
  // Line side per port
  input wire logic [7:0] hook_off,
  input wire logic [7:0] digit_valid,
  input wire logic [7:0][3:0] digit_code,
  // Ring control per port
  input wire logic [7:0] ring_cmd,
  input wire logic [7:0] ring_stop,
  output logic [7:0] ring_relay,
  output logic [7:0] ring_disabled,
  // Event reporting per port
  output logic [7:0] hook_state,
  output logic [7:0] hook_event,
  output logic [7:0] digit_event,
  output logic [7:0][3:0] digit_out
);
  // Backplane slot counter
  logic [7:0] slot_r, slot_nxt;

  // Slot count restarts on frame, steps on each slot
  always_comb begin
    slot_nxt = slot_r;
    if (bp_frame) begin
      slot_nxt = '0;
    end else if (bp_slot_tick) begin
      slot_nxt = slot_r + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) slot_r <= '0;
    else slot_r <= slot_nxt;
  end

  // Codec clock from a phase accumulator; 10 MHz gives no exact divide
  logic [line_port_pkg::NCO_W-1:0] nco_r, nco_nxt;
  logic cclk_r, cclk_nxt, fs_r, fs_nxt, bit_tick, half_tick;
  logic [line_port_pkg::NCO_W:0] nco_sum;
  line_port_pkg::seq_e seq_r, seq_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic frame_done;

  // Accumulator, clock toggle, framing sequencer
  always_comb begin
    nco_sum = {1'b0, nco_r} + {1'b0, (rate_e1 ? line_port_pkg::NCO_INC_E1
                                              : line_port_pkg::NCO_INC_T1)};
    nco_nxt = nco_sum[line_port_pkg::NCO_W-1:0];
    half_tick = nco_sum[line_port_pkg::NCO_W];
    cclk_nxt = half_tick ? ~cclk_r : cclk_r;
    // Bits advance on the rising edge of the codec clock
    bit_tick = half_tick && !cclk_r;
    seq_nxt = seq_r;
    bit_nxt = bit_r;
    fs_nxt = fs_r;
    frame_done = 1'b0;
    if (bit_tick) begin
      case (seq_r)
        line_port_pkg::SEQ_SYNC: begin
          fs_nxt = 1'b1;
          bit_nxt = '0;
          seq_nxt = line_port_pkg::SEQ_SHIFT;
        end
        line_port_pkg::SEQ_SHIFT: begin
          fs_nxt = 1'b0;
          bit_nxt = bit_r + 3'h1;
          if (bit_r == line_port_pkg::BIT_LAST) begin
            frame_done = 1'b1;
            seq_nxt = line_port_pkg::SEQ_SYNC;
          end
        end
        default: seq_nxt = line_port_pkg::SEQ_SYNC;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      nco_r <= '0;
      cclk_r <= 1'b0;
      fs_r <= 1'b0;
      bit_r <= '0;
      seq_r <= line_port_pkg::SEQ_SYNC;
    end else begin
      nco_r <= nco_nxt;
      cclk_r <= cclk_nxt;
      fs_r <= fs_nxt;
      bit_r <= bit_nxt;
      seq_r <= seq_nxt;
    end
  end

  // Shared codec control, one law setting for every port
  assign codec_clk = cclk_r;
  assign codec_fs = fs_r;
  assign codec_alaw = law_alaw;

  // Bytes deserialised from each codec, handed to the loader
  logic [7:0][7:0] tx_byte_r;

  // Per-port channels
  genvar p;
  generate
    for (p = 0; p < line_port_pkg::NPORT; p++) begin : g_port
      logic [7:0] hold_a_r, hold_a_nxt, hold_b_r, hold_b_nxt;
      logic [7:0] sr_a_r, sr_a_nxt, sr_b_r, sr_b_nxt, des_r, des_nxt;
      logic [7:0] txb_nxt;
      logic hk1_r, hk2_r, hk3_r, dv1_r, dv2_r, dv3_r;
      logic ring_r, ring_nxt, dis_r, dis_nxt;
      logic hev_r, hev_nxt, dev_r, dev_nxt;
      logic [3:0] dig_r, dig_nxt;

      // PCM capture, shift, deserialise and event logic
      always_comb begin
        hold_a_nxt = hold_a_r;
        hold_b_nxt = hold_b_r;
        // Both buses caught at the port's own slot
        if (bp_slot_tick && !bp_frame && slot_r == rx_slot[p]) begin
          hold_a_nxt = bp_a_din;
          hold_b_nxt = bp_b_din;
        end
        sr_a_nxt = sr_a_r;
        sr_b_nxt = sr_b_r;
        des_nxt = des_r;
        txb_nxt = tx_byte_r[p];
        if (bit_tick && seq_r == line_port_pkg::SEQ_SYNC) begin
          // Parallel load at frame start; later captures wait a frame
          sr_a_nxt = hold_a_r;
          sr_b_nxt = hold_b_r;
        end else if (bit_tick) begin
          sr_a_nxt = {sr_a_r[6:0], 1'b0};
          sr_b_nxt = {sr_b_r[6:0], 1'b0};
          des_nxt = {des_r[6:0], codec_din[p]};
        end
        if (frame_done) txb_nxt = {des_r[6:0], codec_din[p]};
        // Ring relay: trip and disable win over a same-cycle command
        ring_nxt = ring_r;
        dis_nxt = dis_r;
        if (ring_cmd[p]) begin
          ring_nxt = 1'b1;
          dis_nxt = 1'b0;
        end
        if (ring_stop[p]) ring_nxt = 1'b0;
        // Trip on the reported hook state, so trip and hook event agree
        if (hk3_r && ring_r) begin
          ring_nxt = 1'b0;
          dis_nxt = 1'b1;
        end
        // Events on synchronised edges only
        hev_nxt = hk2_r ^ hk3_r;
        dev_nxt = dv2_r && !dv3_r;
        dig_nxt = dev_nxt ? digit_code[p] : dig_r;
      end

      always_ff @(posedge mclk) begin
        if (!rstn) begin
          hold_a_r <= '0;
          hold_b_r <= '0;
          sr_a_r <= '0;
          sr_b_r <= '0;
          des_r <= '0;
          tx_byte_r[p] <= '0;
          {hk1_r, hk2_r, hk3_r} <= 3'h0;
          {dv1_r, dv2_r, dv3_r} <= 3'h0;
          ring_r <= 1'b0;
          dis_r <= 1'b0;
          hev_r <= 1'b0;
          dev_r <= 1'b0;
          dig_r <= '0;
        end else begin
          hold_a_r <= hold_a_nxt;
          hold_b_r <= hold_b_nxt;
          sr_a_r <= sr_a_nxt;
          sr_b_r <= sr_b_nxt;
          des_r <= des_nxt;
          tx_byte_r[p] <= txb_nxt;
          // Two-flop synchronisers; digit valid comes from another clock
          hk1_r <= hook_off[p];
          hk2_r <= hk1_r;
          hk3_r <= hk2_r;
          dv1_r <= digit_valid[p];
          dv2_r <= dv1_r;
          dv3_r <= dv2_r;
          ring_r <= ring_nxt;
          dis_r <= dis_nxt;
          hev_r <= hev_nxt;
          dev_r <= dev_nxt;
          dig_r <= dig_nxt;
        end
      end

      // Bus select chooses the serial source for this codec
      assign codec_dout[p] = rx_bus_sel[p] ? sr_b_r[7] : sr_a_r[7];
      assign ring_relay[p] = ring_r;
      assign ring_disabled[p] = dis_r;
      assign hook_state[p] = hk3_r;
      assign hook_event[p] = hev_r;
      assign digit_event[p] = dev_r;
      assign digit_out[p] = dig_r;
    end
  endgenerate

  // Loader walks the ports into the FIFO, stalling on full
  logic [3:0] ld_r, ld_nxt;
  logic [7:0][7:0] snap_r, snap_nxt;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [line_port_pkg::TXW_W-1:0] f_in_data, f_out_data;

  always_comb begin
    ld_nxt = ld_r;
    snap_nxt = snap_r;
    f_in_valid = (ld_r != line_port_pkg::LOAD_DONE);
    f_in_data = {ld_r[2:0], snap_r[ld_r[2:0]]};
    if (f_in_valid && f_in_ready) ld_nxt = ld_r + 4'h1;
    // Codec bytes refresh the snapshot; each backplane frame restarts the walk
    // so all eight ports leave in their own slots of every frame
    if (frame_done) snap_nxt = tx_byte_r;
    if (bp_frame) ld_nxt = '0;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ld_r <= line_port_pkg::LOAD_DONE;
      snap_r <= '0;
    end else begin
      ld_r <= ld_nxt;
      snap_r <= snap_nxt;
    end
  end

  tx_fifo #(
    .WIDTH(line_port_pkg::TXW_W),
    .DEPTH(line_port_pkg::TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Drain: head word leaves in its own slot, base plus port index
  logic [7:0] dout_r, dout_nxt;
  logic aoe_r, aoe_nxt, boe_r, boe_nxt;

  always_comb begin
    f_out_ready = bp_slot_tick && !bp_frame && f_out_valid &&
      (slot_r == tx_base_slot + {5'h00, f_out_data[10:8]});
    dout_nxt = dout_r;
    aoe_nxt = aoe_r;
    boe_nxt = boe_r;
    if (bp_slot_tick || bp_frame) begin
      aoe_nxt = f_out_ready && !tx_bus_sel;
      boe_nxt = f_out_ready && tx_bus_sel;
      if (f_out_ready) dout_nxt = f_out_data[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dout_r <= '0;
      aoe_r <= 1'b0;
      boe_r <= 1'b0;
    end else begin
      dout_r <= dout_nxt;
      aoe_r <= aoe_nxt;
      boe_r <= boe_nxt;
    end
  end

  assign bp_dout = dout_r;
  assign bp_a_oe = aoe_r;
  assign bp_b_oe = boe_r;
endmodule : line_port_core

// ===== verif/line_port_chk.sv
// Concurrent checks on the line card port logic, bound to its top module
`timescale 1ns/1ps
module line_port_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Static configuration
  input wire logic rate_e1,
  input wire logic law_alaw,
  input wire logic tx_bus_sel,
  // Codec and backplane outputs
  input wire logic codec_clk,
  input wire logic codec_fs,
  input wire logic codec_alaw,
  input wire logic bp_a_oe,
  input wire logic bp_b_oe,
  input wire logic [7:0] digit_event,
  // Line and ring per port
  input wire logic [7:0] hook_off,
  input wire logic [7:0] ring_cmd,
  input wire logic [7:0] ring_stop,
  input wire logic [7:0] ring_relay,
  input wire logic [7:0] ring_disabled,
  input wire logic [7:0] hook_state,
  input wire logic [7:0] hook_event
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic clk_q_r, clk_q_nxt; // Codec clock one cycle ago
  logic seen_r, seen_nxt; // A rise seen since reset, so the gap is real
  logic [3:0] gap_r, gap_nxt; // Cycles since last rise, saturating
  logic rise; // Codec clock goes high now
  // Period counter next values
  always_comb begin
    rise = codec_clk && !clk_q_r;
    clk_q_nxt = codec_clk;
    seen_nxt = seen_r || rise;
    gap_nxt = rise ? 4'h1 : gap_r + {3'h0, gap_r != 4'hf};
  end
  // Period counter registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      clk_q_r <= 1'b0;
      seen_r <= 1'b0;
      gap_r <= 4'h0;
    end else begin
      clk_q_r <= clk_q_nxt;
      seen_r <= seen_nxt;
      gap_r <= gap_nxt;
    end
  end
  // Bit period is 4-5 cycles at the fast rate, 6-7 at the slow one
  a_clk_rate: assert property (rise && seen_r |->
    (rate_e1 ? gap_r inside {[4'h4:4'h5]} : gap_r inside {[4'h6:4'h7]}))
    else $error("codec clock period off");
  a_law_shared: assert property (codec_alaw == law_alaw)
    else $error("law output differs from setting");
  a_fs_width: assert property ($rose(codec_fs) |-> codec_fs[*3] ##[1:5] !codec_fs)
    else $error("frame sync not one bit period");
  a_tx_one_bus: assert property (bp_a_oe || bp_b_oe |->
    bp_b_oe == tx_bus_sel && bp_a_oe != tx_bus_sel) else $error("wrong bus driven");
  // Per-port ring and hook relations
  for (genvar p = 0; p < 8; p++) begin : g_port
    a_trip_drops_relay: assert property (ring_relay[p] && hook_state[p]
      |=> !ring_relay[p] && ring_disabled[p]) else $error("relay kept after off-hook");
    a_ring_stays_off: assert property (ring_disabled[p] && !ring_relay[p] &&
      !ring_cmd[p] |=> !ring_relay[p]) else $error("relay back without command");
    a_cmd_energises: assert property (ring_cmd[p] && !ring_stop[p] &&
      !(ring_relay[p] && hook_state[p]) |=> ring_relay[p]) else $error("relay not set");
    a_stop_drops: assert property (ring_stop[p] && !ring_cmd[p] |=> !ring_relay[p])
      else $error("relay not dropped");
    a_hook_sync_delay: assert property ($rose(hook_off[p]) |-> !hook_state[p][*2])
      else $error("hook used before synchronising");
    a_hook_event_edge: assert property ($changed(hook_state[p]) |-> ##[0:1] hook_event[p])
      else $error("hook change not reported");
  end
  // Main scenarios reached
  c_trip: cover property ($fell(|ring_relay) && |ring_disabled);
  c_digit: cover property (|digit_event);
  c_tx: cover property (bp_a_oe || bp_b_oe);
  c_fs: cover property ($rose(codec_fs));
endmodule : line_port_chk
bind line_port_core line_port_chk line_port_chk_i (.*);

// ===== verif/pcm_far_model.sv
// Backplane slot timing with per-slot bytes on both buses, and codecs in loopback
`timescale 1ns/1ps
module pcm_far_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Backplane side
  output logic bp_frame,
  output logic bp_slot_tick,
  output logic [7:0] bp_a_din,
  output logic [7:0] bp_b_din,
  // Codec side
  input wire logic [7:0] codec_dout,
  output logic [7:0] codec_din
);
  logic [1:0] ph_r = 2'h0; // Cycle within a slot
  logic [7:0] slot_r = 8'h00; // Slot now on the bus
  // Codec echoes its input, so transmit bytes mirror the bytes listened to
  assign codec_din = codec_dout;
  // Every slot differs, and the buses differ, so a wrong pick shows
  assign bp_a_din = slot_r ^ 8'ha5;
  assign bp_b_din = {slot_r[3:0], slot_r[7:4]};
  // Strobe every fourth cycle; frame start replaces the strobe of slot 39
  always @(posedge mclk) begin
    if (!rstn) begin
      ph_r <= 2'h0;
      slot_r <= 8'h00;
      bp_frame <= 1'b0;
      bp_slot_tick <= 1'b0;
    end else begin
      ph_r <= ph_r + 2'h1;
      bp_frame <= ph_r == 2'h3 && slot_r == 8'h27;
      bp_slot_tick <= ph_r == 2'h3 && slot_r != 8'h27;
      if (bp_frame) slot_r <= 8'h00;
      else if (bp_slot_tick) slot_r <= slot_r + 8'h01;
    end
  end
endmodule : pcm_far_model

// ===== verif/testbench.sv
// Self-checking bench for the line card port logic
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0, rstn = 1'b0; // Clock and reset
  logic rate_e1 = 1'b0, law_alaw = 1'b0, tx_bus_sel = 1'b0; // Static setup
  logic [7:0][7:0] rx_slot = '0; // Listen slot per port
  logic [7:0] rx_bus_sel = 8'h00, tx_base_slot = 8'h00;
  logic bp_frame, bp_slot_tick, bp_a_oe, bp_b_oe, codec_clk, codec_fs, codec_alaw;
  logic [7:0] bp_a_din, bp_b_din, bp_dout, codec_dout, codec_din;
  logic [7:0] hook_off = 8'h00, digit_valid = 8'h00, ring_cmd = 8'h00, ring_stop = 8'h00;
  logic [7:0] ring_relay, ring_disabled, hook_state, hook_event, digit_event;
  logic [7:0][3:0] digit_code = '0, digit_out;
  logic [7:0] exp_relay, exp_dis, n, s, k; // Expected ring state, watcher scratch
  logic [7:0] notes[$]; // Expected events: {digit, port, value}
  logic t, f, armed = 1'b0, tx_chk = 1'b0; // Strobe, frame seen; whole frame; data settled
  int err_count = 0, cmp_count = 0, q, sent = 0;
  integer seed = 32'h1caf;
  line_port_core line_port_core_i (.*);
  pcm_far_model pcm_far_model_i (.*);
  always #50 mclk = ~mclk;
  // Compare and count
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : cyc
  task ring_chk;
    check(ring_relay, exp_relay);
    check(ring_disabled, exp_dis);
  endtask : ring_chk
  // One-cycle ring command or stop pulse
  task ring(input int p, input bit stop);
    if (stop) ring_stop[p] = 1'b1;
    else ring_cmd[p] = 1'b1;
    cyc(1);
    ring_cmd = 8'h00;
    ring_stop = 8'h00;
    exp_relay[p] = !stop;
    if (!stop) exp_dis[p] = 1'b0;
  endtask : ring
  task hook(input int p, input bit v);
    hook_off[p] = v;
    notes.push_back({1'b0, 3'(p), 3'h0, v});
    cyc(8);
  endtask : hook
  // Reset with fresh random setup; the rate flips each time
  task do_reset;
    rstn = 1'b0;
    tx_chk = 1'b0;
    rate_e1 = !rate_e1;
    {rx_bus_sel, law_alaw, tx_bus_sel} = 10'($random(seed));
    tx_base_slot = 8'($unsigned($random(seed)) % 32);
    for (int j = 0; j < 8; j++) rx_slot[j] = 8'($unsigned($random(seed)) % 39);
    exp_relay = 8'h00;
    exp_dis = 8'h00;
    cyc(10);
    check({bp_a_oe, bp_b_oe, codec_fs, codec_clk}, 8'h00);
    ring_chk();
    rstn = 1'b1;
    cyc(600);
    tx_chk = 1'b1;
  endtask : do_reset
  function automatic logic [7:0] rx_byte(input logic [2:0] p);
    return rx_bus_sel[p] ? {rx_slot[p][3:0], rx_slot[p][7:4]} : rx_slot[p] ^ 8'ha5;
  endfunction : rx_byte
  // Event watcher takes the oldest note for each event seen
  always @(posedge mclk) begin
    #2;
    for (int p = 0; p < 8; p++) begin
      if (hook_event[p] === 1'b1) begin
        n = notes.size() ? notes.pop_front() : 8'hxx;
        check({1'b0, 3'(p), 3'h0, hook_state[p]}, n);
      end
      if (digit_event[p] === 1'b1) begin
        n = notes.size() ? notes.pop_front() : 8'hxx;
        check({1'b1, 3'(p), digit_out[p]}, n);
      end
    end
  end
  // Transmit watcher: port k leaves at the strobe ending slot base+k
  always @(posedge mclk) begin
    s = pcm_far_model_i.slot_r;
    t = bp_slot_tick | bp_frame;
    f = bp_frame;
    #2;
    k = s - tx_base_slot;
    // A whole frame since the data settled carries all eight ports
    if (f) begin
      if (tx_chk && armed) check(8'(sent), 8'h08);
      armed = tx_chk;
      sent = 0;
    end
    if (tx_chk && t && (bp_a_oe || bp_b_oe)) begin
      sent++;
      check(k < 8, 8'h01);
      check(bp_dout, rx_byte(k[2:0]));
      check(bp_b_oe, tx_bus_sel);
    end
  end
  // Main sequence
  initial begin
    do_reset();
    for (int p = 0; p < 8; p++) begin
      ring(p, 1'b0);
      ring_chk();
      hook(p, 1'b1);
      exp_relay[p] = 1'b0;
      exp_dis[p] = 1'b1;
      ring_chk();
      hook(p, 1'b0);
      ring_chk();
      ring(p, 1'b0);
      ring_chk();
      ring(p, 1'b1);
      ring_chk();
    end
    q = $unsigned($random(seed)) % 8;
    hook(q, 1'b1);
    ring(q, 1'b0);
    cyc(3);
    exp_relay[q] = 1'b0;
    exp_dis[q] = 1'b1;
    ring_chk();
    hook(q, 1'b0);
    // Tones and gaps arrive already qualified; the bench shortens them to 6 cycles
    for (int i = 0; i < 16; i++) begin
      digit_code[i % 8] = 4'(i);
      digit_valid[i % 8] = 1'b1;
      notes.push_back({1'b1, 3'(i % 8), 4'(i)});
      cyc(6);
      digit_valid = 8'h00;
      cyc(6);
    end
    cyc(400);
    do_reset();
    cyc(400);
    check(8'(notes.size()), 8'h00);
    wrap_up();
  end
  // Watchdog far beyond the expected run of some 2500 cycles
  initial begin
    #1000000;
    err_count++;
    wrap_up();
  end
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
endmodule : testbench
